/* File: icm_ctrl.sv */
// i2c slave control register and channel switch for a four-way bus mux
//
// Summary of operation
// - four downstream clock/data pairs joinable upstream
// - control register alone selects joined channels
// - interrupt output is AND of inputs
// - reset clears register, state, deselects channels
// - three select pins form low address bits
`timescale 1ns/1ns
module icm_ctrl
    import icm_pkg::*;
(
    // clock and reset
    input  wire logic                      clk_sys_in,
    input  wire logic                      arst_n_in,
    // upstream bus
    input  wire logic                      scl_in,
    input  wire logic                      sda_in,
    output logic                           sda_oe_n_out,
    // address select pins
    input  wire logic                      addr_select_bit0_in,
    input  wire logic                      addr_select_bit1_in,
    input  wire logic                      addr_select_bit2_in,
    // downstream channels: join enables and interrupts
    output logic [ICM_CHANNELS-1:0]        chan_join_out,
    input  wire logic [ICM_CHANNELS-1:0]   channel_irq_in_n,
    output logic                           irq_out_n,
    // register view
    output logic [7:0]                     ctrl_reg_out
);
    logic [1:0]                    scl_sync;
    logic [1:0]                    sda_sync;
    logic [ICM_ADDR_SEL_W-1:0]     asel_meta;
    logic [ICM_ADDR_SEL_W-1:0]     asel_sync;
    logic [ICM_CHANNELS-1:0]       irq_meta;
    logic [ICM_CHANNELS-1:0]       irq_sync;
    logic                          scl_q;
    logic                          sda_q;
    logic [7:0]                    ctrl;
    logic [7:0]                    shreg;
    logic [2:0]                    bitcnt;
    logic                          rd_mode;
    // set on the eighth rise; the fall that ends a start is no bit
    logic                          byte_full;
    icm_state_t                    state;

    // two-flop synchronisers for every pin except clock and reset
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            scl_sync  <= 2'h3;
            sda_sync  <= 2'h3;
            asel_meta <= '0;
            asel_sync <= '0;
            irq_meta  <= '1;
            irq_sync  <= '1;
            scl_q     <= 1'b1;
            sda_q     <= 1'b1;
        end else begin
            scl_sync  <= {scl_sync[0], scl_in};
            sda_sync  <= {sda_sync[0], sda_in};
            asel_meta <= {addr_select_bit2_in, addr_select_bit1_in, addr_select_bit0_in};
            asel_sync <= asel_meta;
            irq_meta  <= channel_irq_in_n;
            irq_sync  <= irq_meta;
            scl_q     <= scl_sync[1];
            sda_q     <= sda_sync[1];
        end
    end

    wire scl_s     = scl_sync[1];
    wire sda_s     = sda_sync[1];
    wire scl_rise  = scl_s & ~scl_q;
    wire scl_fall  = ~scl_s & scl_q;
    wire start_det = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_det  = scl_s & scl_q & ~sda_q & sda_s;
    wire [7:0] own_addr = {1'b0, ICM_ADDR_FIXED, asel_sync};

    // bus state machine; master drives the clock, its 400 kHz limit is not checked
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state   <= ICM_IDLE;
            bitcnt  <= ICM_BIT_FIRST;
            shreg   <= '0;
            rd_mode <= 1'b0;
            byte_full <= 1'b0;
        end else if (start_det) begin
            state  <= ICM_ADDR;
            bitcnt <= ICM_BIT_FIRST;
            byte_full <= 1'b0;
        end else if (stop_det) begin
            state <= ICM_IDLE;
        end else begin
            case (state)
                ICM_IDLE: begin
                end
                ICM_ADDR, ICM_WRITE: begin
                    if (scl_rise) begin
                        shreg     <= {shreg[6:0], sda_s};
                        bitcnt    <= bitcnt - 3'h1;
                        byte_full <= (bitcnt == ICM_BIT_LAST);
                    end
                    if (scl_fall && byte_full) begin
                        byte_full <= 1'b0;
                        if (state == ICM_WRITE) begin
                            state <= ICM_WRITE_ACK;
                        end else if (shreg[7:1] == own_addr[6:0]) begin
                            state   <= ICM_ADDR_ACK;
                            rd_mode <= shreg[0];
                        end else begin
                            state <= ICM_IDLE;
                        end
                    end
                end
                ICM_ADDR_ACK, ICM_WRITE_ACK: begin
                    if (scl_fall) begin
                        bitcnt <= ICM_BIT_FIRST;
                        state  <= rd_mode ? ICM_READ : ICM_WRITE;
                        if (rd_mode) begin
                            shreg <= ctrl;
                        end
                    end
                end
                ICM_READ: begin
                    if (scl_fall) begin
                        shreg  <= {shreg[6:0], 1'b0};
                        bitcnt <= bitcnt - 3'h1;
                        if (bitcnt == ICM_BIT_LAST) begin
                            state <= ICM_READ_ACK;
                        end
                    end
                end
                ICM_READ_ACK: begin
                    if (scl_rise) begin
                        state <= sda_s ? ICM_IDLE : ICM_READ_ACK;
                    end
                    if (scl_fall && state == ICM_READ_ACK) begin
                        shreg  <= ctrl;
                        bitcnt <= ICM_BIT_FIRST;
                        state  <= ICM_READ;
                    end
                end
                default: state <= ICM_IDLE;
            endcase
        end
    end

    // control register load on each written byte
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctrl <= ICM_CTRL_RESET;
        end else if (state == ICM_WRITE && scl_fall && byte_full) begin
            ctrl <= shreg;
        end
    end

    // open-drain data drive, low enable means pulling low
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sda_oe_n_out <= 1'b1;
        end else begin
            case (state)
                ICM_ADDR_ACK, ICM_WRITE_ACK: sda_oe_n_out <= 1'b0;
                ICM_READ:                    sda_oe_n_out <= shreg[7];
                default:                     sda_oe_n_out <= 1'b1;
            endcase
        end
    end

    // channel joins, interrupt combine
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            chan_join_out <= '0;
            irq_out_n     <= 1'b1;
            ctrl_reg_out  <= ICM_CTRL_RESET;
        end else begin
            for (int i = 0; i < ICM_CHANNELS; i++) begin
                chan_join_out[i] <= ctrl[ICM_EN_BIT] && (ctrl[1:0] == 2'(i));
            end
            irq_out_n    <= &irq_sync;
            ctrl_reg_out <= ctrl;
        end
    end

    AST_JOIN_MATCH: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        ##1 chan_join_out == (($past(ctrl[ICM_EN_BIT])) ? (4'h1 << $past(ctrl[1:0])) : 4'h0))
        else $error("channel join does not follow register");
    AST_ONEHOT: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        $onehot0(chan_join_out))
        else $error("more than one channel joined");
    AST_IRQ_AND: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        ##1 irq_out_n == &$past(irq_sync))
        else $error("interrupt output not AND of inputs");
    AST_CTRL_STABLE: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (state != ICM_WRITE) |=> $stable(ctrl))
        else $error("register changed outside a write");
    AST_ACK_DRIVE: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (state == ICM_ADDR_ACK) |=> !sda_oe_n_out)
        else $error("no acknowledge drive");
    AST_IDLE_RELEASE: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (state == ICM_IDLE) |=> sda_oe_n_out)
        else $error("data driven while idle");
    AST_ADDR_MATCH: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        ($rose(state == ICM_ADDR_ACK)) |-> $past(shreg[7:1]) == own_addr[6:0])
        else $error("acknowledged wrong address");
    AST_START_ADDR: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        start_det |=> state == ICM_ADDR)
        else $error("start not taken");
    AST_WRITE_ACK: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (state == ICM_WRITE_ACK) |=> !sda_oe_n_out)
        else $error("no acknowledge of data byte");
    AST_JOIN_OFF: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        !ctrl[ICM_EN_BIT] |=> chan_join_out == 4'h0)
        else $error("channel joined while disabled");

    COV_WRITE: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        state == ICM_WRITE_ACK);
    COV_READ: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        state == ICM_READ_ACK);
    COV_JOIN: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        chan_join_out != 4'h0);
    COV_FOREIGN: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        state == ICM_ADDR && scl_fall && byte_full && shreg[7:1] != own_addr[6:0]);
endmodule : icm_ctrl

/* File: icm_pkg.sv */
// shared constants for the i2c channel mux controller
package icm_pkg;
    localparam int          ICM_CHANNELS     = 4;
    localparam int          ICM_ADDR_SEL_W   = 3;
    localparam logic [3:0]  ICM_ADDR_FIXED   = 4'hE;
    localparam logic [7:0]  ICM_CTRL_RESET   = 8'h00;
    localparam int          ICM_EN_BIT       = 2;
    localparam logic [2:0]  ICM_BIT_LAST     = 3'h0;
    localparam logic [2:0]  ICM_BIT_FIRST    = 3'h7;
    localparam int          ICM_SCL_MAX_KHZ  = 400;

    typedef enum logic [2:0] {
        ICM_IDLE,
        ICM_ADDR,
        ICM_ADDR_ACK,
        ICM_WRITE,
        ICM_WRITE_ACK,
        ICM_READ,
        ICM_READ_ACK
    } icm_state_t;
endpackage : icm_pkg

/* File: icm_master_model.sv */
// i2c master model for the upstream pair
`timescale 1ns/1ns
module icm_master_model (
    // clock
    input  wire logic clk_sys_in,
    // upstream bus
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_out
);
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // quarter of an 800 ns bit runs scl at 1.25 MHz, above the 400 kHz ceiling
    task automatic qtr;
        repeat (2) @(negedge clk_sys_in);
    endtask : qtr
    task automatic start_cond;
        sda_out = 1'b1;
        scl_out = 1'b1;
        qtr();
        sda_out = 1'b0;
        qtr();
        scl_out = 1'b0;
        qtr();
    endtask : start_cond
    task automatic stop_cond;
        sda_out = 1'b0;
        qtr();
        scl_out = 1'b1;
        qtr();
        sda_out = 1'b1;
        qtr();
    endtask : stop_cond
    // eight bits msb first then the ack slot; a 1 releases the line
    task automatic xfer(input logic [7:0] d, input logic last,
                        output logic [7:0] r, output logic ack);
        logic [8:0] sh;
        sh = {d, last};
        for (int i = 8; i >= 0; i--) begin
            sda_out = sh[i];
            qtr();
            scl_out = 1'b1;
            qtr();
            sh[i] = sda_in;
            qtr();
            scl_out = 1'b0;
            qtr();
        end
        r   = sh[8:1];
        ack = sh[0];
    endtask : xfer
endmodule : icm_master_model

/* File: icm_ctrl_tb.sv */
// self-checking bench for the channel mux controller
`timescale 1ns/1ns
module icm_ctrl_tb import icm_pkg::*; ;
    logic       clk_sys_in = 1'b0;
    logic       arst_n_in  = 1'b0;
    logic       scl, msda, sda_oe_n_out, irq_out_n, ack;
    wire logic  sda_wire = msda & sda_oe_n_out;
    logic [2:0] a_sel      = 3'h0;
    logic [3:0] chan_join_out;
    logic [3:0] irq_n      = 4'hF;
    logic [7:0] ctrl_reg_out, r, v;
    logic [7:0] exp_q[$];
    logic [7:0] vals[5]    = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h03};
    logic [31:0] lfsr      = 32'h93C5;
    int         n_mismatch = 0;
    int         n_tests    = 0;
    int         cyc        = 0;
    always #50 clk_sys_in = ~clk_sys_in;
    icm_master_model icm_master_model_inst (.clk_sys_in(clk_sys_in), .sda_in(sda_wire),
        .scl_out(scl), .sda_out(msda));
    icm_ctrl icm_ctrl_inst (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .scl_in(scl),
        .sda_in(sda_wire), .sda_oe_n_out(sda_oe_n_out), .addr_select_bit0_in(a_sel[0]),
        .addr_select_bit1_in(a_sel[1]), .addr_select_bit2_in(a_sel[2]),
        .chan_join_out(chan_join_out), .channel_irq_in_n(irq_n), .irq_out_n(irq_out_n),
        .ctrl_reg_out(ctrl_reg_out));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic xact(input logic [7:0] a, input logic [7:0] d, output logic [7:0] rd);
        logic dack;
        icm_master_model_inst.start_cond();
        icm_master_model_inst.xfer(a, 1'b1, rd, ack);
        icm_master_model_inst.xfer(d, 1'b1, rd, dack);
        icm_master_model_inst.stop_cond();
        repeat (4) @(negedge clk_sys_in);
    endtask : xact
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : step
    always @(ctrl_reg_out) begin
        if (arst_n_in && exp_q.size() > 0) check("ctrl", ctrl_reg_out, exp_q.pop_front());
    end
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        a_sel = lfsr[2:0];
        repeat (10) @(negedge clk_sys_in);
        check("rst", {sda_oe_n_out, irq_out_n, chan_join_out}, 8'h30);
        check("rst_ctrl", ctrl_reg_out, ICM_CTRL_RESET);
        arst_n_in = 1'b1;
        repeat (6) @(negedge clk_sys_in);
        foreach (vals[i]) begin
            v = vals[i];
            exp_q.push_back(v);
            xact({ICM_ADDR_FIXED, a_sel, 1'b0}, v, r);
            check("addr_ack", {7'h0, ack}, 8'h00);
            check("join", {4'h0, chan_join_out},
                  {4'h0, v[ICM_EN_BIT] ? 4'h1 << v[1:0] : 4'h0});
            xact({ICM_ADDR_FIXED, a_sel, 1'b1}, 8'hFF, r);
            check("read", r, v);
        end
        xact({ICM_ADDR_FIXED, a_sel ^ 3'h1, 1'b0}, 8'h06, r);
        check("foreign_ack", {7'h0, ack}, 8'h01);
        check("kept", ctrl_reg_out, v);
        check("queue_left", 8'(exp_q.size()), 8'h00);
        for (int k = 0; k < 8; k++) begin
            lfsr = step(lfsr);
            irq_n = lfsr[3:0];
            repeat (5) @(negedge clk_sys_in);
            check("irq", {7'h0, irq_out_n}, {7'h0, &irq_n});
        end
        irq_n = 4'hF;
        repeat (5) @(negedge clk_sys_in);
        check("irq_idle", {7'h0, irq_out_n}, 8'h01);
        arst_n_in = 1'b0;
        repeat (2) @(negedge clk_sys_in);
        check("rst2", {chan_join_out, 4'h0}, 8'h00);
        check("rst2_ctrl", ctrl_reg_out, ICM_CTRL_RESET);
        arst_n_in = 1'b1;
        repeat (6) @(negedge clk_sys_in);
        xact({ICM_ADDR_FIXED, a_sel, 1'b1}, 8'hFF, r);
        check("rst2_ack", {7'h0, ack}, 8'h00);
        check("rst2_read", r, ICM_CTRL_RESET);
        conclude();
    end
endmodule : icm_ctrl_tb
